//--- shared/ffseq_consts.vh
`ifndef FFSEQ_CONSTS_VH
`define FFSEQ_CONSTS_VH

// ---------------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------------
`define FFSEQ_ADDR_MODE 12'h000
`define FFSEQ_ADDR_DIR 12'h004
`define FFSEQ_ADDR_SEL 12'h008
`define FFSEQ_ADDR_STATUS 12'h00c
`define FFSEQ_ADDR_TIME0 12'h020

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define FFSEQ_MODE_RST 8'h00
`define FFSEQ_DIR_RST 8'h00
`define FFSEQ_TIME_RST 16'h0000
`define FFSEQ_SEL_RST 3'h0

// ---------------------------------------------------------------------
// Mode codes and fields
// ---------------------------------------------------------------------
`define FFSEQ_MODE_OFF 8'h00
`define FFSEQ_MODE_ONCE 8'h01
`define FFSEQ_MODE_CONT 8'h02
`define FFSEQ_MODE_STEP_ONCE 8'h03
`define FFSEQ_MODE_STEP_CONT 8'h04
`define FFSEQ_TIME_MAX 16'h03e8
`define FFSEQ_SEL_START_LSB 0
`define FFSEQ_SEL_PAUSE_LSB 4

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define FFSEQ_CLK_HZ 25000000
`define FFSEQ_TICK_S 1
`define FFSEQ_TICK_CYCLES (`FFSEQ_CLK_HZ * `FFSEQ_TICK_S)

`endif

//--- hw/ffseq_tick.v
`include "ffseq_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module ffseq_tick #(
  parameter integer CYCLES = `FFSEQ_TICK_CYCLES
) (
  input wire clk_sys_i,
  input wire srst_i,
  input wire restart_i,
  output reg tick_o
);

  reg [31:0] cnt_reg;

  // Restart aligns a full second to each step start
  always @(posedge clk_sys_i) begin
    if (srst_i || restart_i) begin
      cnt_reg <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_reg == CYCLES - 1) begin
      cnt_reg <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick_o <= 1'b0;
    end
  end

endmodule // ffseq_tick

`default_nettype wire

//--- hw/ffseq_top.v
`include "ffseq_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module ffseq_top #(
  parameter integer TICK_CYCLES = `FFSEQ_TICK_CYCLES,
  parameter integer NUM_DI = 6
) (
  input wire clk_sys_i,
  input wire srst_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  input wire [NUM_DI-1:0] digital_inputs_i,
  input wire ext_run_i,
  input wire [2:0] ext_step_i,
  input wire ext_reverse_i,
  output reg run_o,
  output reg [2:0] preset_step_o,
  output reg reverse_rotation_o,
  output reg seq_override_o,
  output reg stop_request_o,
  output reg step_end_o,
  output reg cycle_end_o,
  output reg paused_o
);

  // -------------------------------------------------------------------
  // States
  // -------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_RUN = 2'd1;
  localparam [1:0] ST_GAP = 2'd2;
  localparam [1:0] ST_DONE = 2'd3;

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  reg [7:0] sequencer_mode_reg;
  reg [7:0] direction_program_reg;
  reg [2:0] start_input_select_reg;
  reg [2:0] pause_input_select_reg;
  reg [15:0] time_reg [0:7];
  reg [1:0] state_reg;
  reg [2:0] step_reg;
  reg [15:0] sec_reg;
  reg wr_pend_reg;
  reg [11:0] wr_addr_reg;
  reg [7:0] active_mask;
  reg [2:0] first_idx;
  reg [2:0] next_idx;
  reg has_first;
  reg has_next;
  reg start_lvl;
  reg pause_lvl;
  reg mode_on;
  reg mode_step;
  reg mode_cont;
  reg restart_cnt;
  reg [15:0] wdata16;
  integer k;
  integer j;
  wire tick;
  wire addr_ph;
  ffseq_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .restart_i(restart_cnt),
    .tick_o(tick)
  );

  // -------------------------------------------------------------------
  // Decode of settings and inputs
  // -------------------------------------------------------------------
  always @* begin
    mode_on = (sequencer_mode_reg >= `FFSEQ_MODE_ONCE) &&
              (sequencer_mode_reg <= `FFSEQ_MODE_STEP_CONT);
    mode_step = (sequencer_mode_reg == `FFSEQ_MODE_STEP_ONCE) ||
                (sequencer_mode_reg == `FFSEQ_MODE_STEP_CONT);
    mode_cont = (sequencer_mode_reg == `FFSEQ_MODE_CONT) ||
                (sequencer_mode_reg == `FFSEQ_MODE_STEP_CONT);
    start_lvl = 1'b0;
    if (start_input_select_reg != 3'h0 &&
        start_input_select_reg <= NUM_DI) begin
      start_lvl = digital_inputs_i[start_input_select_reg - 3'h1];
    end
    pause_lvl = 1'b0;
    if (pause_input_select_reg != 3'h0 &&
        pause_input_select_reg <= NUM_DI) begin
      pause_lvl = digital_inputs_i[pause_input_select_reg - 3'h1];
    end
    for (k = 0; k < 8; k = k + 1) begin
      active_mask[k] = (time_reg[k] != 16'h0000);
    end
    has_first = 1'b0;
    first_idx = 3'h0;
    for (k = 7; k >= 0; k = k - 1) begin
      if (active_mask[k]) begin
        has_first = 1'b1;
        first_idx = k[2:0];
      end
    end
    has_next = 1'b0;
    next_idx = 3'h0;
    for (k = 7; k >= 0; k = k - 1) begin
      if (active_mask[k] && (k > step_reg)) begin
        has_next = 1'b1;
        next_idx = k[2:0];
      end
    end
  end

  // -------------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // -------------------------------------------------------------------
  assign addr_ph = hsel_i && hready_i && htrans_i[1];
  always @* begin
    wdata16 = hwdata_i[15:0];
    if (wdata16 > `FFSEQ_TIME_MAX) begin
      wdata16 = `FFSEQ_TIME_MAX;
    end
  end
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      hrdata_o <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      sequencer_mode_reg <= `FFSEQ_MODE_RST;
      direction_program_reg <= `FFSEQ_DIR_RST;
      start_input_select_reg <= `FFSEQ_SEL_RST;
      pause_input_select_reg <= `FFSEQ_SEL_RST;
      for (j = 0; j < 8; j = j + 1) begin
        time_reg[j] <= `FFSEQ_TIME_RST;
      end
    end else begin
      wr_pend_reg <= addr_ph && hwrite_i;
      wr_addr_reg <= haddr_i[11:0];
      if (wr_pend_reg) begin
        case (wr_addr_reg)
          `FFSEQ_ADDR_MODE: begin
            sequencer_mode_reg <= hwdata_i[7:0];
          end
          `FFSEQ_ADDR_DIR: begin
            direction_program_reg <= hwdata_i[7:0];
          end
          `FFSEQ_ADDR_SEL: begin
            start_input_select_reg <=
              hwdata_i[`FFSEQ_SEL_START_LSB +: 3];
            pause_input_select_reg <=
              hwdata_i[`FFSEQ_SEL_PAUSE_LSB +: 3];
          end
          default: begin
            if (wr_addr_reg[11:5] == `FFSEQ_ADDR_TIME0 >> 5 &&
                wr_addr_reg[1:0] == 2'b00) begin
              time_reg[wr_addr_reg[4:2]] <= wdata16;
            end
          end
        endcase
      end
      if (addr_ph && !hwrite_i) begin
        case (haddr_i[11:0])
          `FFSEQ_ADDR_MODE: hrdata_o <= {24'h0, sequencer_mode_reg};
          `FFSEQ_ADDR_DIR: hrdata_o <= {24'h0, direction_program_reg};
          `FFSEQ_ADDR_SEL: begin
            hrdata_o <= {25'h0, pause_input_select_reg, 1'b0,
                         start_input_select_reg};
          end
          `FFSEQ_ADDR_STATUS: begin
            hrdata_o <= {8'h0, sec_reg, 1'b0, step_reg, paused_o,
                         run_o, state_reg};
          end
          default: begin
            if (haddr_i[11:5] == `FFSEQ_ADDR_TIME0 >> 5) begin
              hrdata_o <= {16'h0, time_reg[haddr_i[4:2]]};
            end else begin
              hrdata_o <= 32'h0;
            end
          end
        endcase
      end
    end
  end

  // -------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------
  always @* begin
    restart_cnt = 1'b0;
    if (state_reg == ST_IDLE || !start_lvl || !mode_on) begin
      restart_cnt = 1'b1;
    end else if (tick && !pause_lvl &&
                 sec_reg + 16'h1 >= time_reg[step_reg]) begin
      restart_cnt = 1'b1;
    end
  end
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_reg <= ST_IDLE;
      step_reg <= 3'h0;
      sec_reg <= 16'h0;
      step_end_o <= 1'b0;
      cycle_end_o <= 1'b0;
      paused_o <= 1'b0;
    end else begin
      step_end_o <= 1'b0;
      cycle_end_o <= 1'b0;
      paused_o <= 1'b0;
      if (!start_lvl || !mode_on || !has_first) begin
        state_reg <= ST_IDLE;
        step_reg <= 3'h0;
        sec_reg <= 16'h0;
      end else if (pause_lvl && state_reg != ST_IDLE) begin
        paused_o <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            step_reg <= first_idx;
            sec_reg <= 16'h0;
            state_reg <= ST_RUN;
          end
          ST_RUN: begin
            if (tick) begin
              if (sec_reg + 16'h1 >= time_reg[step_reg]) begin
                step_end_o <= 1'b1;
                sec_reg <= 16'h0;
                if (mode_step) begin
                  state_reg <= ST_GAP;
                end else if (has_next) begin
                  step_reg <= next_idx;
                end else if (mode_cont) begin
                  cycle_end_o <= 1'b1;
                  step_reg <= first_idx;
                end else begin
                  cycle_end_o <= 1'b1;
                  state_reg <= ST_DONE;
                end
              end else begin
                sec_reg <= sec_reg + 16'h1;
              end
            end
          end
          ST_GAP: begin
            // Stop request lasts one cycle per step boundary, or as long as a pause holds the gap
            if (has_next) begin
              step_reg <= next_idx;
              state_reg <= ST_RUN;
            end else if (mode_cont) begin
              cycle_end_o <= 1'b1;
              step_reg <= first_idx;
              state_reg <= ST_RUN;
            end else begin
              cycle_end_o <= 1'b1;
              state_reg <= ST_DONE;
            end
          end
          ST_DONE: begin
            // Single cycle finished; needs start to drop first
            state_reg <= ST_DONE;
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // -------------------------------------------------------------------
  // Drive outputs
  // -------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      run_o <= 1'b0;
      preset_step_o <= 3'h0;
      reverse_rotation_o <= 1'b0;
      seq_override_o <= 1'b0;
      stop_request_o <= 1'b0;
    end else begin
      seq_override_o <= mode_on && start_lvl && has_first;
      if (mode_on && start_lvl && has_first) begin
        run_o <= (state_reg == ST_RUN) && !pause_lvl;
        preset_step_o <= step_reg;
        reverse_rotation_o <= direction_program_reg[step_reg];
        stop_request_o <= (state_reg == ST_GAP);
      end else begin
        run_o <= ext_run_i;
        preset_step_o <= ext_step_i;
        reverse_rotation_o <= ext_reverse_i;
        stop_request_o <= 1'b0;
      end
    end
  end

endmodule // ffseq_top
`default_nettype wire

//--- dv/ffseq_di_model.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------------
// Digital input terminals
// ---------------------------------------------------------------------
module ffseq_di_model (
  input wire logic clk_sys_i,
  input wire logic start_i,
  input wire logic pause_i,
  input wire logic [2:0] start_sel_i,
  input wire logic [2:0] pause_sel_i,
  output logic [5:0] di_o
);
  logic [5:0] di_next;
  always_comb begin
    di_next = 6'h00;
    if (start_sel_i != 3'h0) di_next[start_sel_i - 3'h1] = start_i;
    if (pause_sel_i != 3'h0) di_next[pause_sel_i - 3'h1] = pause_i;
  end
  always_ff @(posedge clk_sys_i) begin
    di_o <= di_next;
  end
endmodule // ffseq_di_model
`default_nettype wire

//--- dv/ffseq_top_asserts.sv
`include "ffseq_consts.vh"
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------------
module ffseq_top_asserts (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic ext_run_i,
  input wire logic [2:0] ext_step_i,
  input wire logic run_o,
  input wire logic [2:0] preset_step_o,
  input wire logic reverse_rotation_o,
  input wire logic seq_override_o,
  input wire logic stop_request_o,
  input wire logic step_end_o,
  input wire logic cycle_end_o,
  input wire logic paused_o
);
  logic w_q;
  logic [11:0] a_q;
  logic [7:0] mode_q;
  logic [7:0] dir_q;
  // Mirror mode and direction, stored at end of data phase
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      w_q <= 1'b0;
      a_q <= 12'h000;
      mode_q <= 8'h00;
      dir_q <= 8'h00;
    end else begin
      w_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
      a_q <= haddr_i[11:0];
      if (w_q && a_q == `FFSEQ_ADDR_MODE) mode_q <= hwdata_i[7:0];
      if (w_q && a_q == `FFSEQ_ADDR_DIR) dir_q <= hwdata_i[7:0];
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  property p_ovr_mode;
    seq_override_o |-> mode_q inside {8'h01, 8'h02, 8'h03, 8'h04};
  endproperty
  a_ovr_mode: assert property (p_ovr_mode)
    else $error("run in off mode");
  property p_stop_mode;
    stop_request_o |-> mode_q inside {8'h03, 8'h04};
  endproperty
  a_stop_mode: assert property (p_stop_mode)
    else $error("stop unstepped");
  property p_dir;
    seq_override_o && run_o |-> reverse_rotation_o == dir_q[preset_step_o];
  endproperty
  a_dir: assert property (p_dir)
    else $error("wrong direction bit");
  property p_step_pulse;
    step_end_o |=> !step_end_o;
  endproperty
  a_step_pulse: assert property (p_step_pulse)
    else $error("step end long");
  property p_stop_pulse;
    stop_request_o |=> !stop_request_o;
  endproperty
  a_stop_pulse: assert property (p_stop_pulse)
    else $error("stop long");
  property p_cyc_pulse;
    cycle_end_o |=> !cycle_end_o;
  endproperty
  a_cyc_pulse: assert property (p_cyc_pulse)
    else $error("cycle end long");
  property p_pause;
    paused_o ##1 paused_o |-> !run_o;
  endproperty
  a_pause: assert property (p_pause)
    else $error("runs while paused");
  property p_pass;
    !seq_override_o ##1 !seq_override_o |->
      run_o == $past(ext_run_i) && preset_step_o == $past(ext_step_i);
  endproperty
  a_pass: assert property (p_pass)
    else $error("other source lost");
  c_step: cover property (step_end_o);
  c_stop: cover property (stop_request_o);
  c_pause: cover property (paused_o);
  c_cyc: cover property (cycle_end_o);
endmodule // ffseq_top_asserts
bind ffseq_top ffseq_top_asserts u_chk (.clk_sys_i(clk_sys_i),
  .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .ext_run_i(ext_run_i), .ext_step_i(ext_step_i),
  .run_o(run_o), .preset_step_o(preset_step_o),
  .reverse_rotation_o(reverse_rotation_o), .seq_override_o(seq_override_o),
  .stop_request_o(stop_request_o), .step_end_o(step_end_o),
  .cycle_end_o(cycle_end_o), .paused_o(paused_o));
`default_nettype wire

//--- dv/tb.sv
`include "ffseq_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, hwrite_i = 1'b0, start = 1'b0;
  logic pause = 1'b0, ext_run_i = 1'b0, ext_reverse_i = 1'b0, sr_seen;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, rd, hrdata_o;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] ext_step_i = 3'h0, cur, preset_step_o;
  logic [5:0] di;
  logic hreadyout_o, hresp_o, run_o, reverse_rotation_o, seq_override_o;
  logic stop_request_o, step_end_o, cycle_end_o, paused_o;
  // Run times stay longer than any ramp
  logic [15:0] tt [8] = '{16'h1, 16'h0, 16'h2, 16'h0,
    16'h0, 16'h0, 16'h0, 16'h1};
  logic [2:0] stp [3] = '{3'h0, 3'h2, 3'h7};
  int bad_count = 0, num_checks = 0;
  localparam int TK = 10;
  localparam logic [7:0] DIRW = 8'h84;
  time t0;
  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (stop_request_o === 1'b1) sr_seen = 1'b1;
  ffseq_top #(.TICK_CYCLES(TK)) uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .hsel_i(1'b1), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .digital_inputs_i(di), .ext_run_i(ext_run_i),
    .ext_step_i(ext_step_i), .ext_reverse_i(ext_reverse_i), .run_o(run_o),
    .preset_step_o(preset_step_o), .reverse_rotation_o(reverse_rotation_o),
    .seq_override_o(seq_override_o), .stop_request_o(stop_request_o),
    .step_end_o(step_end_o), .cycle_end_o(cycle_end_o), .paused_o(paused_o));
  ffseq_di_model u_di (.clk_sys_i(clk_sys_i), .start_i(start),
    .pause_i(pause), .start_sel_i(3'h1), .pause_sel_i(3'h2), .di_o(di));
  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  function automatic bit cnd(input int k);
    if (k == 1) return cycle_end_o === 1'b1;
    return run_o === 1'b1 && seq_override_o === 1'b1 && preset_step_o !== cur;
  endfunction
  // Bounded wait, a hang ends the run
  task automatic wt(input int k);
    int n;
    for (n = 0; n < 500 && !cnd(k); n++) @(posedge clk_sys_i);
    if (n >= 500) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    htrans_i <= 2'h2;
    haddr_i <= {20'h0, a};
    hwrite_i <= w;
    rdy();
    htrans_i <= 2'h0;
    hwdata_i <= d;
    rdy();
    rd = hrdata_o;
  endtask
  // ---------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      ahb(1'b0, (i < 3) ? 12'(4 * i) :
        (i < 11) ? 12'(20 + 4 * i) : 12'h100, 0);
      check(rd, 32'h0);
    end
    $display("test reset values done");
    ahb(1'b1, `FFSEQ_ADDR_TIME0, 32'h7d0);
    ahb(1'b0, `FFSEQ_ADDR_TIME0, 32'h0);
    check(rd, 32'h3e8);
    ahb(1'b1, `FFSEQ_ADDR_DIR, 32'h1ff);
    ahb(1'b0, `FFSEQ_ADDR_DIR, 32'h0);
    check(rd, 32'hff);
    ahb(1'b1, `FFSEQ_ADDR_DIR, {24'h0, DIRW});
    ahb(1'b1, `FFSEQ_ADDR_SEL, 32'h21);
    for (int i = 0; i < 8; i++) ahb(1'b1, 12'(32 + 4 * i), {16'h0, tt[i]});
    $display("test registers done");
    ext_run_i <= 1'b1;
    ext_step_i <= 3'h5;
    ext_reverse_i <= 1'b1;
    start <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    check(seq_override_o, 1'b0);
    check({run_o, reverse_rotation_o, preset_step_o}, 5'h1d);
    start <= 1'b0;
    ext_run_i <= 1'b0;
    ext_reverse_i <= 1'b0;
    $display("test mode off done");
    for (int m = 1; m < 5; m++) begin
      ahb(1'b1, `FFSEQ_ADDR_MODE, 32'(m));
      sr_seen = 1'b0;
      cur = 3'h7;
      start <= 1'b1;
      for (int j = 0; j < 3; j++) begin
        wt(0);
        cur = stp[j];
        if (j == 1) t0 = $time;
        check(preset_step_o, stp[j]);
        check(run_o, 1'b1);
        check(reverse_rotation_o, DIRW[stp[j]]);
      end
      check(32'(($time - t0) / 40), 32'(tt[2]) * TK + 1);
      wt(1);
      check(sr_seen, m > 2);
      if (m % 2 == 1) begin
        repeat (3) @(posedge clk_sys_i);
        check(run_o, 1'b0);
        ahb(1'b0, `FFSEQ_ADDR_STATUS, 32'h0);
        check(rd[7:2], 6'h1c);
      end else begin
        wt(0);
        check(preset_step_o, 3'h0);
        pause <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        check({paused_o, run_o}, 2'b10);
        pause <= 1'b0;
        // Look before the next tick can move the step on
        repeat (3) @(posedge clk_sys_i);
        check({run_o, preset_step_o}, 4'h8);
      end
      start <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      check(seq_override_o, 1'b0);
      $display("test mode %0d done", m);
    end
    print_verdict();
  end
endmodule // tb
`default_nettype wire
